//--- src/pvit_pkg.sv
package pvit_pkg;

  // ****************************************************************
  // clocking and pixel clock
  // ****************************************************************
  localparam int unsigned CLK_KHZ   = 250000;
  localparam int unsigned PCLK_DIV  = 8;
  localparam int unsigned PCLK_KHZ  = CLK_KHZ / PCLK_DIV;
  localparam logic [2:0]  PCLK_HALF = 3'(PCLK_DIV / 2);

  // ****************************************************************
  // blanking minimums, lines or pixel clocks
  // ****************************************************************
  localparam logic [11:0] VS_MIN     = 12'h001;
  localparam logic [11:0] VBP_MIN    = 12'h002;
  localparam logic [11:0] VFP_MIN    = 12'h001;
  localparam logic [11:0] VBLANK_MIN = 12'h00c;
  localparam logic [11:0] HS_MIN     = 12'h004;
  localparam logic [11:0] HBP_MIN    = 12'h004;
  localparam logic [11:0] HFP_MIN    = 12'h008;

  // ****************************************************************
  // device register: frame_sync_line_offset
  // ****************************************************************
  localparam logic [7:0]  FRAME_SYNC_LINE_OFFSET_ADDR = 8'h23;
  localparam logic [7:0]  FRAME_SYNC_LINE_OFFSET_RST  = 8'h05;
  localparam logic [11:0] LINE_DLY_BASE    = 12'h006;
  localparam logic [11:0] LINE_DLY_VBP_SUB = 12'h002;
  localparam logic [11:0] LINE_DLY_MAX     = 12'h00f;

  // ****************************************************************
  // source formats
  // ****************************************************************
  typedef enum logic [3:0] {
    FMT_NTSC, FMT_PAL, FMT_QVGA, FMT_QWVGA, FMT_VGA32, FMT_VGA43,
    FMT_WVGA720, FMT_WVGA752, FMT_WVGA800, FMT_WVGA_WIDE, FMT_OPTICAL
  } pvit_fmt_t;

  typedef enum {ST_IDLE, ST_RUN} pvit_state_t;

  // maximum line rate in khz, zero where the orientation is unsupported
  function automatic int unsigned pvit_rate_khz(pvit_fmt_t f, logic portrait);
    case (f)
      FMT_NTSC:      pvit_rate_khz = portrait ? 0 : 17;
      FMT_PAL:       pvit_rate_khz = portrait ? 0 : 20;
      FMT_QVGA:      pvit_rate_khz = portrait ? 22 : 17;
      FMT_QWVGA:     pvit_rate_khz = portrait ? 27 : 17;
      FMT_VGA32:     pvit_rate_khz = portrait ? 45 : 30;
      FMT_VGA43:     pvit_rate_khz = portrait ? 45 : 34;
      FMT_WVGA720:   pvit_rate_khz = portrait ? 51 : 34;
      FMT_WVGA752:   pvit_rate_khz = portrait ? 53 : 34;
      FMT_WVGA800:   pvit_rate_khz = portrait ? 56 : 34;
      FMT_WVGA_WIDE: pvit_rate_khz = portrait ? 56 : 34;
      FMT_OPTICAL:   pvit_rate_khz = portrait ? 0 : 48;
      default:       pvit_rate_khz = 0;
    endcase
  endfunction

  // shortest line in pixel clocks: roundup(1000 * f_mhz / rate_khz)
  function automatic logic [11:0] pvit_min_line(pvit_fmt_t f, logic portrait);
    int unsigned r;
    r = pvit_rate_khz(f, portrait);
    pvit_min_line = (r == 0) ? 12'hfff : 12'((PCLK_KHZ + r - 1) / r);
  endfunction

endpackage

//--- src/pvit_pclk_gen.sv
`timescale 1ns/1ps
module pvit_pclk_gen (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic capture_falling,
  output logic      pclk_q,
  output logic      pre_q,
  output logic      launch_q
);
  import pvit_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] launch_at;

  assign cnt_d = cnt_q + 3'h1;
  // launch lands on the edge opposite the device's capture edge
  assign launch_at = capture_falling ? 3'h7 : PCLK_HALF - 3'h1;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q    <= 3'h0;
      pclk_q   <= 1'b0;
      pre_q    <= 1'b0;
      launch_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      pclk_q   <= cnt_d < PCLK_HALF;
      pre_q    <= cnt_d == launch_at - 3'h1;
      launch_q <= cnt_d == launch_at;
    end
  end
endmodule // pvit_pclk_gen

//--- src/pvit_video_source.sv
// Functional notes
// - frame sync stays high at least one whole line every frame.
// - at least two lines from frame sync lead to first active line sync.
// - at least one line from line after last active line to frame sync.
// - vertical back plus front porch totals twelve lines or more.
// - line sync high at least four pixel clocks every line.
// - horizontal back porch at least four pixel clocks before valid strobe.
// - line length at least roundup(1000*fclk/rate); blanking fills the rest.
// - line offset kept within max(0,6-vfp) and min(15,vbp-2).
// - line rate never exceeds the limit of format and orientation.
// - ntsc and pal are landscape only; portrait is refused.
`timescale 1ns/1ps
module pvit_video_source (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               enable,
  input  wire logic               capture_falling,
  input  wire pvit_pkg::pvit_fmt_t cfg_fmt,
  input  wire logic               cfg_portrait,
  input  wire logic [11:0]        active_pixels_per_line,
  input  wire logic [11:0]        cfg_active_lines,
  input  wire logic [11:0]        cfg_vsync_lines,
  input  wire logic [11:0]        cfg_vbp,
  input  wire logic [11:0]        cfg_vfp,
  input  wire logic [11:0]        cfg_hsync_pclks,
  input  wire logic [11:0]        cfg_hbp,
  input  wire logic [11:0]        cfg_hfp,
  input  wire logic [23:0]        pixel_data,
  input  wire logic               pixel_data_valid,
  input  wire logic               underrun_clr,
  output logic                    pixel_ready_q,
  output logic                    vid_pclk,
  output logic                    vid_vsync_q,
  output logic                    vid_hsync_q,
  output logic                    pixel_valid_strobe_q,
  output logic [23:0]             pixel_bus_q,
  output logic                    running_q,
  output logic                    cfg_err_q,
  output logic                    underrun_q,
  output logic [7:0]              line_offset_q,
  output logic                    offset_err_q
);
  import pvit_pkg::*;

  // ****************************************************************
  // pixel clock
  // ****************************************************************
  logic pre;
  logic launch;

  pvit_pclk_gen u_pclk (
    .clk             (clk),
    .rst             (rst),
    .capture_falling (capture_falling),
    .pclk_q          (vid_pclk),
    .pre_q           (pre),
    .launch_q        (launch)
  );

  // ****************************************************************
  // effective timing from user settings
  // ****************************************************************
  logic [11:0] e_vbp, e_vs, e_vfp, e_hs, e_hbp, e_hfp, e_line, e_min, e_frame, e_hsum;
  logic        e_ok;

  always_comb begin
    e_ok   = pvit_rate_khz(cfg_fmt, cfg_portrait) != 0;
    e_min  = pvit_min_line(cfg_fmt, cfg_portrait);
    e_vbp  = (cfg_vbp < VBP_MIN) ? VBP_MIN : cfg_vbp;
    e_vs   = (cfg_vsync_lines < VS_MIN) ? VS_MIN : cfg_vsync_lines;
    if (e_vs > e_vbp) begin
      e_vs = e_vbp;
    end
    e_vfp  = (cfg_vfp < VFP_MIN) ? VFP_MIN : cfg_vfp;
    if (e_vbp + e_vfp < VBLANK_MIN) begin
      e_vfp = VBLANK_MIN - e_vbp;
    end
    e_hs   = (cfg_hsync_pclks < HS_MIN) ? HS_MIN : cfg_hsync_pclks;
    e_hbp  = (cfg_hbp < HBP_MIN) ? HBP_MIN : cfg_hbp;
    e_hfp  = (cfg_hfp < HFP_MIN) ? HFP_MIN : cfg_hfp;
    e_hsum = e_hs + e_hbp + active_pixels_per_line + e_hfp;
    // front porch stretched so the line meets the rate limit
    e_line = (e_hsum < e_min) ? e_min : e_hsum;
    e_frame = e_vbp + cfg_active_lines + e_vfp;
  end

  // ****************************************************************
  // frame and line counters
  // ****************************************************************
  pvit_state_t state_q;
  logic [11:0] h_q, v_q;
  logic [11:0] cur_vbp_q, cur_vs_q, cur_vfp_q, cur_hs_q, cur_hbp_q;
  logic [11:0] cur_line_q, cur_min_q, cur_frame_q, cur_active_pixels_per_line_q, cur_lines_q;
  logic        go, wrap_h, wrap_v, start, stop, live;
  logic [11:0] hn, vn, s_vbp, s_vs, s_hs, s_hbp, s_active_pixels_per_line, s_lines, hact;
  logic        act_n;

  always_comb begin
    go     = enable && e_ok;
    wrap_h = h_q == cur_line_q - 12'h001;
    wrap_v = wrap_h && (v_q == cur_frame_q - 12'h001);
    start  = (state_q == ST_IDLE) ? go : (wrap_v && go);
    stop   = (state_q == ST_RUN) && wrap_v && !go;
    live   = start || ((state_q == ST_RUN) && !stop);
    hn     = (start || wrap_h) ? 12'h000 : h_q + 12'h001;
    vn     = start ? 12'h000 : (wrap_h ? v_q + 12'h001 : v_q);
    s_vbp  = start ? e_vbp : cur_vbp_q;
    s_vs   = start ? e_vs : cur_vs_q;
    s_hs   = start ? e_hs : cur_hs_q;
    s_hbp  = start ? e_hbp : cur_hbp_q;
    s_active_pixels_per_line = start ? active_pixels_per_line : cur_active_pixels_per_line_q;
    s_lines = start ? cfg_active_lines : cur_lines_q;
    hact   = s_hs + s_hbp;
    act_n  = live && (vn >= s_vbp) && (vn < s_vbp + s_lines) && (hn >= hact) && (hn < hact + s_active_pixels_per_line);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      h_q     <= 12'h000;
      v_q     <= 12'h000;
    end else if (launch) begin
      state_q <= live ? ST_RUN : ST_IDLE;
      h_q     <= hn;
      v_q     <= vn;
    end
  end

  // settings only change at a frame boundary
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_vbp_q   <= VBP_MIN;
      cur_vs_q    <= VS_MIN;
      cur_vfp_q   <= VBLANK_MIN - VBP_MIN;
      cur_hs_q    <= HS_MIN;
      cur_hbp_q   <= HBP_MIN;
      cur_line_q  <= 12'hfff;
      cur_min_q   <= 12'hfff;
      cur_frame_q <= 12'hfff;
      cur_active_pixels_per_line_q  <= 12'h000;
      cur_lines_q <= 12'h000;
    end else if (launch && start) begin
      cur_vbp_q   <= e_vbp;
      cur_vs_q    <= e_vs;
      cur_vfp_q   <= e_vfp;
      cur_hs_q    <= e_hs;
      cur_hbp_q   <= e_hbp;
      cur_line_q  <= e_line;
      cur_min_q   <= e_min;
      cur_frame_q <= e_frame;
      cur_active_pixels_per_line_q  <= active_pixels_per_line;
      cur_lines_q <= cfg_active_lines;
    end
  end

  // ****************************************************************
  // pins toward the device
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      vid_vsync_q          <= 1'b0;
      vid_hsync_q          <= 1'b0;
      pixel_valid_strobe_q <= 1'b0;
      pixel_bus_q          <= 24'h000000;
      running_q            <= 1'b0;
    end else if (launch) begin
      vid_hsync_q          <= live && (hn < s_hs);
      vid_vsync_q          <= live && (vn < s_vs);
      pixel_valid_strobe_q <= act_n;
      pixel_bus_q          <= (act_n && pixel_data_valid) ? pixel_data : 24'h000000;
      running_q            <= live;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pixel_ready_q <= 1'b0;
    end else begin
      pixel_ready_q <= pre && act_n;
    end
  end

  // set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      underrun_q <= 1'b0;
    end else if (pixel_ready_q && !pixel_data_valid) begin
      underrun_q <= 1'b1;
    end else if (underrun_clr) begin
      underrun_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_err_q <= 1'b0;
    end else begin
      cfg_err_q <= enable && !e_ok;
    end
  end

  // ****************************************************************
  // value to program into frame_sync_line_offset
  // ****************************************************************
  logic [11:0] dly_lo, dly_hi, dly_rec;

  always_comb begin
    dly_lo = (cur_vfp_q >= LINE_DLY_BASE) ? 12'h000 : LINE_DLY_BASE - cur_vfp_q;
    dly_hi = cur_vbp_q - LINE_DLY_VBP_SUB;
    if (dly_hi > LINE_DLY_MAX) begin
      dly_hi = LINE_DLY_MAX;
    end
    dly_rec = {4'h0, FRAME_SYNC_LINE_OFFSET_RST};
    if (dly_rec < dly_lo) begin
      dly_rec = dly_lo;
    end else if (dly_rec > dly_hi) begin
      dly_rec = dly_hi;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      line_offset_q <= FRAME_SYNC_LINE_OFFSET_RST;
      offset_err_q  <= 1'b0;
    end else begin
      line_offset_q <= dly_rec[7:0];
      offset_err_q  <= dly_lo > dly_hi;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [15:0] hs_cnt_q, hbp_cnt_q, line_cnt_q;
  logic [23:0] vs_cnt_q;
  logic [11:0] ln_since_vs_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      hs_cnt_q      <= 16'h0000;
      hbp_cnt_q     <= 16'h0000;
      line_cnt_q    <= 16'hffff;
      vs_cnt_q      <= 24'h000000;
      ln_since_vs_q <= 12'h000;
    end else begin
      hs_cnt_q   <= vid_hsync_q ? hs_cnt_q + 16'h0001 : 16'h0000;
      hbp_cnt_q  <= $fell(vid_hsync_q) ? 16'h0001 : hbp_cnt_q + {15'h0000, hbp_cnt_q != 16'hffff};
      line_cnt_q <= $rose(vid_hsync_q) ? 16'h0001 : line_cnt_q + {15'h0000, line_cnt_q != 16'hffff};
      vs_cnt_q   <= vid_vsync_q ? vs_cnt_q + 24'h000001 : 24'h000000;
      if ($rose(vid_vsync_q)) begin
        ln_since_vs_q <= 12'h001;
      end else if ($rose(vid_hsync_q) && ln_since_vs_q != 12'hfff) begin
        ln_since_vs_q <= ln_since_vs_q + 12'h001;
      end
    end
  end

  sequence s_vs_rise;
    $rose(vid_vsync_q);
  endsequence

  sequence s_hs_rise;
    $rose(vid_hsync_q);
  endsequence

  property p_vs_width;
    @(posedge clk) disable iff (rst)
      $fell(vid_vsync_q) |-> vs_cnt_q >= 24'(cur_line_q) * 24'(PCLK_DIV);
  endproperty
  a_vs_width: assert property (p_vs_width) else $error("frame sync shorter than one line");

  property p_vs_with_hs;
    @(posedge clk) disable iff (rst)
      s_vs_rise |-> s_hs_rise;
  endproperty
  a_vs_with_hs: assert property (p_vs_with_hs) else $error("frame sync not aligned to line sync");

  property p_vbp;
    @(posedge clk) disable iff (rst)
      $rose(pixel_valid_strobe_q) |-> ln_since_vs_q >= VBP_MIN + 12'h001;
  endproperty
  a_vbp: assert property (p_vbp) else $error("vertical back porch too short");

  property p_vfp;
    @(posedge clk) disable iff (rst)
      running_q |-> cur_vfp_q >= VFP_MIN && cur_vbp_q + cur_vfp_q >= VBLANK_MIN;
  endproperty
  a_vfp: assert property (p_vfp) else $error("vertical blanking too short");

  property p_hs_width;
    @(posedge clk) disable iff (rst)
      $fell(vid_hsync_q) |-> hs_cnt_q >= 16'(HS_MIN) * 16'(PCLK_DIV);
  endproperty
  a_hs_width: assert property (p_hs_width) else $error("line sync too short");

  property p_hbp;
    @(posedge clk) disable iff (rst)
      $rose(pixel_valid_strobe_q) |-> hbp_cnt_q >= 16'(HBP_MIN) * 16'(PCLK_DIV);
  endproperty
  a_hbp: assert property (p_hbp) else $error("horizontal back porch too short");

  property p_line_rate;
    @(posedge clk) disable iff (rst)
      s_hs_rise |-> line_cnt_q >= 16'(cur_min_q) * 16'(PCLK_DIV);
  endproperty
  a_line_rate: assert property (p_line_rate) else $error("line rate above limit");

  property p_offset;
    @(posedge clk) disable iff (rst)
      (dly_lo <= dly_hi) |=> (12'(line_offset_q) >= $past(dly_lo) && 12'(line_offset_q) <= $past(dly_hi));
  endproperty
  a_offset: assert property (p_offset) else $error("line offset out of range");

  property p_refuse;
    @(posedge clk) disable iff (rst)
      (enable && cfg_portrait && (cfg_fmt == FMT_NTSC || cfg_fmt == FMT_PAL)) |=> cfg_err_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("portrait broadcast format not refused");

  property p_valid_blank;
    @(posedge clk) disable iff (rst)
      pixel_valid_strobe_q |-> !vid_hsync_q && running_q;
  endproperty
  a_valid_blank: assert property (p_valid_blank) else $error("valid strobe during blanking");
endmodule // pvit_video_source

//--- testbench/pvit_dev_model.sv
`timescale 1ns/1ps
module pvit_dev_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        capture_falling,
  input  wire logic        vid_pclk,
  input  wire logic        vid_vsync,
  input  wire logic        vid_hsync,
  input  wire logic        pixel_valid_strobe,
  input  wire logic [23:0] pixel_bus,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata
);
  import pvit_pkg::*;
  logic        pclk_d;
  logic        hs_p;
  logic        vs_p;
  logic        dv_p;
  logic        seen;
  logic        cap;
  logic [7:0]  offset_q;
  logic [23:0] first_pix;
  int lines, frames, pc, li, vsl, vs_len, hs_cnt, hs_w, hbp_len, npix, first_act, last_act, vfp_len, line_len;

  // ****************************************************************
  // register file
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      offset_q <= FRAME_SYNC_LINE_OFFSET_RST;
    end else if (reg_wr && reg_addr == FRAME_SYNC_LINE_OFFSET_ADDR) begin
      offset_q <= reg_wdata;
    end
  end
  assign reg_rdata = (reg_addr == FRAME_SYNC_LINE_OFFSET_ADDR) ? offset_q : 8'h00;

  // ****************************************************************
  // pin capture and timing measurement
  // ****************************************************************
  // pixel clock is sampled by clk; capture edge chosen by capture_falling
  assign cap = capture_falling ? (pclk_d && !vid_pclk) : (!pclk_d && vid_pclk);
  always @(posedge clk) begin
    pclk_d <= vid_pclk;
    if (rst) begin
      {hs_p, vs_p, dv_p, seen} = 4'h0;
      {lines, frames, pc, li, vsl, vs_len, hs_cnt, npix} = '0;
    end else if (cap) begin
      if (vid_hsync && !hs_p) begin
        if (lines > 0) line_len = pc;
        lines++;
        pc = 0;
        hs_cnt = 0;
        li++;
        if (vid_vsync && !vs_p) begin
          if (frames > 0) vfp_len = li - 1 - last_act;
          vs_len = vsl;
          frames++;
          li = 0;
          vsl = 0;
          seen = 1'b0;
        end
        if (vid_vsync) vsl++;
      end
      if (vid_hsync) hs_cnt++;
      // bus taken only while the valid strobe is high
      if (pixel_valid_strobe) begin
        if (!dv_p) begin
          hs_w = hs_cnt;
          hbp_len = pc - hs_cnt;
          first_pix = pixel_bus;
          npix = 0;
          if (!seen) first_act = li;
          seen = 1'b1;
          last_act = li;
        end
        npix++;
      end
      pc++;
      hs_p = vid_hsync;
      vs_p = vid_vsync;
      dv_p = pixel_valid_strobe;
    end
  end
endmodule // pvit_dev_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pvit_pkg::*;
  typedef struct {pvit_fmt_t fmt; logic prt; logic err; int unsigned r;} pvit_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        enable = 1'b0;
  logic        capture_falling = 1'b0;
  pvit_fmt_t   cfg_fmt = FMT_WVGA800;
  logic        cfg_portrait = 1'b0;
  logic [11:0] cfg_vs = 12'h002;
  logic [11:0] cfg_vbp = 12'h004;
  logic [11:0] cfg_vfp = 12'h008;
  logic [11:0] cfg_hs = 12'h005;
  logic [23:0] pixel_data = 24'h0;
  logic [23:0] pix_cnt = 24'h0;
  logic        pixel_data_valid = 1'b1;
  logic        underrun_clr = 1'b0;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        pixel_ready_q, vid_pclk, vid_vsync_q, vid_hsync_q, pixel_valid_strobe_q;
  logic        running_q, cfg_err_q, underrun_q, offset_err_q;
  logic [23:0] pixel_bus_q;
  logic [7:0]  line_offset_q;
  logic [7:0]  reg_rdata;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  pvit_row_t   rows [6] = '{'{FMT_WVGA800, 1'b1, 1'b0, 56}, '{FMT_OPTICAL, 1'b0, 1'b0, 48},
                            '{FMT_VGA32, 1'b1, 1'b0, 45}, '{FMT_NTSC, 1'b1, 1'b1, 0},
                            '{FMT_PAL, 1'b1, 1'b1, 0}, '{FMT_OPTICAL, 1'b1, 1'b1, 0}};

  always #2 clk = ~clk;

  pvit_video_source DUT (
    .clk(clk), .rst(rst), .enable(enable), .capture_falling(capture_falling),
    .cfg_fmt(cfg_fmt), .cfg_portrait(cfg_portrait), .active_pixels_per_line(12'h010),
    .cfg_active_lines(12'h002), .cfg_vsync_lines(cfg_vs), .cfg_vbp(cfg_vbp), .cfg_vfp(cfg_vfp),
    .cfg_hsync_pclks(cfg_hs), .cfg_hbp(12'h004), .cfg_hfp(12'h008), .pixel_data(pixel_data),
    .pixel_data_valid(pixel_data_valid), .underrun_clr(underrun_clr), .pixel_ready_q(pixel_ready_q),
    .vid_pclk(vid_pclk),
    .vid_vsync_q(vid_vsync_q), .vid_hsync_q(vid_hsync_q), .pixel_valid_strobe_q(pixel_valid_strobe_q),
    .pixel_bus_q(pixel_bus_q), .running_q(running_q), .cfg_err_q(cfg_err_q), .underrun_q(underrun_q),
    .line_offset_q(line_offset_q), .offset_err_q(offset_err_q)
  );

  pvit_dev_model m (
    .clk(clk), .rst(rst), .capture_falling(capture_falling), .vid_pclk(vid_pclk),
    .vid_vsync(vid_vsync_q), .vid_hsync(vid_hsync_q), .pixel_valid_strobe(pixel_valid_strobe_q),
    .pixel_bus(pixel_bus_q), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  // ****************************************************************
  // pixel supply and helpers
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) pix_cnt <= 24'h0;
    else if (pixel_ready_q) pix_cnt <= pix_cnt + 24'h1;
  end
  always @(negedge clk) pixel_data <= pix_cnt;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    enable = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk(32'(line_offset_q), 32'h5);
    chk(32'(reg_rdata), 32'h0);
    reg_addr = FRAME_SYNC_LINE_OFFSET_ADDR;
    @(negedge clk);
    chk(32'(reg_rdata), 32'h5);
    for (int i = 0; i < 6; i++) begin
      do_reset();
      cfg_fmt = rows[i].fmt;
      cfg_portrait = rows[i].prt;
      enable = 1'b1;
      if (rows[i].err) begin
        repeat (40) @(negedge clk);
        chk(32'(cfg_err_q), 32'h1);
        chk(32'(running_q | (m.lines != 0)), 32'h0);
      end else begin
        while (m.lines < 2) @(negedge clk);
        chk(32'(m.line_len >= (PCLK_KHZ + rows[i].r - 1) / rows[i].r), 32'h1);
        chk(32'(line_offset_q), 32'h2);
      end
    end
    // clamped porches, falling capture edge, one whole frame
    do_reset();
    cfg_fmt = FMT_WVGA800;
    cfg_portrait = 1'b1;
    capture_falling = 1'b1;
    {cfg_vs, cfg_vbp, cfg_vfp, cfg_hs} = {12'h001, 12'h001, 12'h001, 12'h004};
    enable = 1'b1;
    // third pixel goes missing while a clear is pending: the set must win
    while (!(pixel_ready_q && pix_cnt == 24'h000002)) @(negedge clk);
    pixel_data_valid = 1'b0;
    underrun_clr = 1'b1;
    @(negedge clk);
    chk(32'(pixel_bus_q), 32'h0);
    chk(32'(underrun_q), 32'h1);
    pixel_data_valid = 1'b1;
    @(negedge clk);
    underrun_clr = 1'b0;
    chk(32'(underrun_q), 32'h0);
    chk(32'(running_q), 32'h1);
    while (m.frames < 2) @(negedge clk);
    chk(32'(m.vs_len), 32'h1);
    chk(32'(m.first_act), 32'(VBP_MIN));
    chk(32'(m.vfp_len), 32'ha);
    chk(32'(m.hs_w), 32'h4);
    chk(32'(m.hbp_len), 32'h4);
    chk(32'(m.npix), 32'h10);
    chk(32'(m.first_pix), 32'h10);
    chk(32'(underrun_q), 32'h0);
    chk(32'(line_offset_q), 32'h0);
    chk(32'(offset_err_q), 32'h0);
    wr_reg(FRAME_SYNC_LINE_OFFSET_ADDR, line_offset_q);
    reg_addr = FRAME_SYNC_LINE_OFFSET_ADDR;
    @(negedge clk);
    chk(32'(reg_rdata), 32'h0);
    tally_and_finish();
  end
endmodule // tb_top
